// ### hdl/hvs_pkg.sv
`default_nettype none
package hvs_pkg;
  localparam int CLK_NS            = 20;
  localparam int HV_LATCH_MIN_NS   = 100;
  localparam int HV_LATCH_MIN_CYC  = (HV_LATCH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEL_HOLD_US       = 10;
  localparam int SEL_HOLD_CYC      = (SEL_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_WAIT_US    = 300;
  localparam int SETTLE_WAIT_CYC   =
    (SETTLE_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int VCC_RAMP_US       = 40;
  localparam int VCC_RAMP_CYC      = (VCC_RAMP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SCI_MIN_PERIOD_NS = 220;
  localparam int SCI_HALF_CYC      =
    (SCI_MIN_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int WAIT_GUARD_CYC    = 8;
  localparam int FRAME_BITS        = 11;

  localparam logic [2:0] SEL_PROG    = 3'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] LOCK_RESET  = 8'hFC;
  localparam logic [7:0] LOCK_ERASED = 8'hFF;

  // Instruction-line codes
  localparam logic [7:0] II_LOAD_CMD = 8'h4C;
  localparam logic [7:0] II_ADDR_LO  = 8'h0C;
  localparam logic [7:0] II_ADDR_HI  = 8'h1C;
  localparam logic [7:0] II_DATA_LO  = 8'h2C;
  localparam logic [7:0] II_DATA_HI  = 8'h3C;
  localparam logic [7:0] II_LATCH_LO = 8'h6D;
  localparam logic [7:0] II_LATCH_HI = 8'h7D;
  localparam logic [7:0] II_STROBE   = 8'h64;
  localparam logic [7:0] II_END      = 8'h6C;
  localparam logic [7:0] II_READ_LO  = 8'h68;
  localparam logic [7:0] II_READ_HI  = 8'h78;

  // Command bytes on the data line
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  typedef enum logic [1:0] {
    HVS_ENTER = 2'b00,
    HVS_FRAME = 2'b01,
    HVS_WAIT  = 2'b10,
    HVS_EXIT  = 2'b11
  } hvs_op_t;

  function automatic logic [10:0] hvs_frame(input logic [7:0] b);
    return {1'b0, b, 2'b00};
  endfunction
endpackage
`default_nettype wire

// ### hdl/hvs_if.sv
`timescale 1ns/1ns
`default_nettype none
interface hvs_if;
  logic       vcc_on;
  logic       hv_reset;
  logic [2:0] sel_out;
  logic [2:0] sel_oe_n;
  logic [2:0] sel;
  logic       serial_data_input;
  logic       serial_instruction_input;
  logic       serial_clock_input;
  logic       sdo_out;
  logic       sdo_oe_n;
  logic       serial_data_output;

  // Released lines read as pulled high
  assign sel = sel_out | sel_oe_n;
  assign serial_data_output = sdo_out | sdo_oe_n;

  modport programmer (
    output vcc_on, hv_reset, sel_out, sel_oe_n, serial_data_input, serial_instruction_input, serial_clock_input,
    input  serial_data_output
  );
  modport device (
    input  vcc_on, hv_reset, sel, serial_data_input, serial_instruction_input, serial_clock_input,
    output sdo_out, sdo_oe_n
  );
endinterface
`default_nettype wire

// ### hdl/hvs_device.sv
// Behaviour
// - Select pins held 000 for 10 us
// - Latch selection after 100 ns high voltage
// - Wait 300 us before first instruction
// - Leave mode on supply loss or reset
// - Keep loaded command and address
// - High address byte selects 256 window
// - Erase clears flash, EEPROM, lock; not fuses
// - Lock bits cleared only after flash erase
// - Keep fuse preserves EEPROM over erase
// - Programmer erases before reprogramming
// - Erase end raises data output
// - Flash written one page per operation
// - Flash page write ends raising output
// - Repeat pages, finish with no-op command
// - EEPROM written one page per operation
// - EEPROM page write ends raising output
// - Sample and shift on clock rise
// - Read flash bytes at selected address
// - Read EEPROM byte at selected address
// - Power-off: clock low, reset high, supply off
`timescale 1ns/1ns
`default_nettype none
module hvs_device
  import hvs_pkg::*;
#(
  parameter int FLASH_WORDS = 512,
  parameter int FPAGE_WORDS = 16,
  parameter int EE_BYTES    = 512,
  parameter int EPAGE_BYTES = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  hvs_if.device           bus,
  input  wire logic       i_eeprom_keep_fuse,
  output logic            o_prog_mode,
  output logic            o_busy,
  output logic [7:0]      o_lock_bits
);
  localparam int FA  = $clog2(FLASH_WORDS);
  localparam int FPW = $clog2(FPAGE_WORDS);
  localparam int EA  = $clog2(EE_BYTES);
  localparam int EPW = $clog2(EPAGE_BYTES);
  typedef enum logic [1:0] {
    MD_OFF = 2'b00, MD_LATCH = 2'b01, MD_PROG = 2'b10, MD_NORMAL = 2'b11
  } hvs_mode_t;
  typedef enum logic [2:0] {
    OP_IDLE = 3'b000, OP_ERASE_F = 3'b001, OP_ERASE_E = 3'b010,
    OP_LOCK = 3'b011, OP_WR_F = 3'b100, OP_WR_E = 3'b101
  } hvs_eng_t;
  typedef struct packed {
    logic [7:0]             s1, s2, cnt;
    hvs_mode_t              mode;
    hvs_eng_t               op;
    logic [15:0]            idx;
    logic [3:0]             bitn;
    logic [10:0]            sdi_sh, sii_sh;
    logic [7:0]             cmd, addr_lo, addr_hi, dat_lo, dat_hi;
    logic [FPAGE_WORDS-1:0] fmask;
    logic [EPAGE_BYTES-1:0] emask;
    logic [7:0]             sdo_sh, lock;
    logic                   sci_prev, armed, sdo_q, sdo_oe_n;
  } hvs_dev_t;
  hvs_dev_t q;
  hvs_dev_t d;
  // Arrays sit outside the state record: too large to reset
  logic [15:0]   flash_mem [FLASH_WORDS];
  logic [7:0]    ee_mem    [EE_BYTES];
  logic [7:0]    fpl       [FPAGE_WORDS];
  logic [7:0]    fph       [FPAGE_WORDS];
  logic [7:0]    epb       [EPAGE_BYTES];
  logic [FA-1:0] fl_wa;
  logic [15:0]   fl_wd;
  logic [EA-1:0] ee_wa;
  logic [7:0]    ee_wd;
  logic          fl_we, ee_we, pl_we, ph_we, eb_we;
  always_comb
  begin
    logic [15:0] wa;
    logic [10:0] nsdi, nsii;
    d     = q;
    wa    = {q.addr_hi, q.addr_lo};
    nsdi  = {q.sdi_sh[9:0], q.s2[2]};
    nsii  = {q.sii_sh[9:0], q.s2[1]};
    fl_we = 1'b0;
    fl_wa = wa[FA-1:0];
    fl_wd = {ERASED_BYTE, ERASED_BYTE};
    ee_we = 1'b0;
    ee_wa = wa[EA-1:0];
    ee_wd = ERASED_BYTE;
    pl_we = 1'b0;
    ph_we = 1'b0;
    eb_we = 1'b0;
    d.s1  = {bus.vcc_on, bus.hv_reset, bus.sel, bus.serial_data_input, bus.serial_instruction_input, bus.serial_clock_input};
    d.s2  = q.s1;
    d.sci_prev = q.s2[0];
    case (q.mode)
      MD_OFF:
        if (q.s2[7] && q.s2[6])
          d.mode = MD_LATCH;
      MD_LATCH:
        if (q.cnt == 8'(HV_LATCH_MIN_CYC - 1))
          d.mode = (q.s2[5:3] == SEL_PROG) ? MD_PROG : MD_NORMAL;
        else
          d.cnt = q.cnt + 8'h01;
      MD_PROG:
        case (q.op)
          OP_IDLE:
            if (q.s2[0] && !q.sci_prev)
            begin
              d.sdi_sh = nsdi;
              d.sii_sh = nsii;
              d.sdo_sh = {q.sdo_sh[6:0], 1'b1};
              if (q.bitn == 4'(FRAME_BITS - 1))
              begin
                d.bitn = '0;
                case (nsii[9:2])
                  II_LOAD_CMD:
                  begin
                    d.cmd   = nsdi[9:2];
                    d.armed = 1'b0;
                  end
                  II_ADDR_LO: d.addr_lo = nsdi[9:2];
                  II_ADDR_HI: d.addr_hi = nsdi[9:2];
                  II_DATA_LO: d.dat_lo = nsdi[9:2];
                  II_DATA_HI: d.dat_hi = nsdi[9:2];
                  II_LATCH_LO:
                    if (q.cmd == CMD_WR_FLASH)
                    begin
                      pl_we = 1'b1;
                      d.fmask[q.addr_lo[FPW-1:0]] = 1'b1;
                    end
                    else if (q.cmd == CMD_WR_EE)
                    begin
                      eb_we = 1'b1;
                      d.emask[q.addr_lo[EPW-1:0]] = 1'b1;
                    end
                  II_LATCH_HI:
                    if (q.cmd == CMD_WR_FLASH)
                    begin
                      ph_we = 1'b1;
                      d.fmask[q.addr_lo[FPW-1:0]] = 1'b1;
                    end
                  II_STROBE: d.armed = 1'b1;
                  II_END:
                    if (q.armed)
                    begin
                      d.armed = 1'b0;
                      d.idx   = '0;
                      case (q.cmd)
                        CMD_ERASE:    d.op = OP_ERASE_F;
                        CMD_WR_FLASH: d.op = OP_WR_F;
                        CMD_WR_EE:    d.op = OP_WR_E;
                        default:      d.op = OP_IDLE;
                      endcase
                    end
                  II_READ_LO:
                    if (q.cmd == CMD_RD_FLASH)
                      d.sdo_sh = flash_mem[wa[FA-1:0]][7:0];
                    else if (q.cmd == CMD_RD_EE)
                      d.sdo_sh = ee_mem[wa[EA-1:0]];
                  II_READ_HI:
                    if (q.cmd == CMD_RD_FLASH)
                      d.sdo_sh = flash_mem[wa[FA-1:0]][15:8];
                  default: d.bitn = '0;
                endcase
              end
              else
                d.bitn = q.bitn + 4'h1;
            end
          OP_ERASE_F:
          begin
            fl_we = 1'b1;
            fl_wa = q.idx[FA-1:0];
            if (q.idx == 16'(FLASH_WORDS - 1))
            begin
              d.idx = '0;
              d.op  = i_eeprom_keep_fuse ? OP_LOCK : OP_ERASE_E;
            end
            else
              d.idx = q.idx + 16'h0001;
          end
          OP_ERASE_E:
          begin
            ee_we = 1'b1;
            ee_wa = q.idx[EA-1:0];
            if (q.idx == 16'(EE_BYTES - 1))
              d.op = OP_LOCK;
            else
              d.idx = q.idx + 16'h0001;
          end
          OP_LOCK:
          begin
            d.lock   = LOCK_ERASED;
            d.op     = OP_IDLE;
            d.sdo_sh = ERASED_BYTE;
          end
          OP_WR_F:
          begin
            fl_we = q.fmask[q.idx[FPW-1:0]];
            fl_wa = {wa[FA-1:FPW], q.idx[FPW-1:0]};
            fl_wd = {fph[q.idx[FPW-1:0]], fpl[q.idx[FPW-1:0]]};
            if (q.idx == 16'(FPAGE_WORDS - 1))
            begin
              d.fmask  = '0;
              d.op     = OP_IDLE;
              d.sdo_sh = ERASED_BYTE;
            end
            else
              d.idx = q.idx + 16'h0001;
          end
          OP_WR_E:
          begin
            ee_we = q.emask[q.idx[EPW-1:0]];
            ee_wa = {wa[EA-1:EPW], q.idx[EPW-1:0]};
            ee_wd = epb[q.idx[EPW-1:0]];
            if (q.idx == 16'(EPAGE_BYTES - 1))
            begin
              d.emask  = '0;
              d.op     = OP_IDLE;
              d.sdo_sh = ERASED_BYTE;
            end
            else
              d.idx = q.idx + 16'h0001;
          end
          default: d.op = OP_IDLE;
        endcase
      default: d.cnt = q.cnt;
    endcase
    // Off state clears entry count and frame state for the next entry
    if (!q.s2[7] || !q.s2[6])
    begin
      d.mode  = MD_OFF;
      d.op    = OP_IDLE;
      d.cnt   = '0;
      d.bitn  = '0;
      d.armed = 1'b0;
    end
    d.sdo_oe_n = (d.mode != MD_PROG);
    d.sdo_q    = (d.op == OP_IDLE) ? d.sdo_sh[7] : 1'b0;
  end
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q          <= '0;
      q.lock     <= LOCK_RESET;
      q.sdo_q    <= 1'b1;
      q.sdo_oe_n <= 1'b1;
    end
    else
      q <= d;
  end
  always_ff @(posedge i_clk)
  begin
    if (fl_we)
      flash_mem[fl_wa] <= fl_wd;
    if (ee_we)
      ee_mem[ee_wa] <= ee_wd;
    if (pl_we)
      fpl[q.addr_lo[FPW-1:0]] <= q.dat_lo;
    if (pl_we || ph_we)
      fph[q.addr_lo[FPW-1:0]] <= ph_we ? q.dat_hi : ERASED_BYTE;
    if (eb_we)
      epb[q.addr_lo[EPW-1:0]] <= q.dat_lo;
  end
  assign bus.sdo_out  = q.sdo_q;
  assign bus.sdo_oe_n = q.sdo_oe_n;
  assign o_prog_mode  = (q.mode == MD_PROG);
  assign o_busy       = (q.op != OP_IDLE);
  assign o_lock_bits  = q.lock;
endmodule // hvs_device
`default_nettype wire

// ### hdl/hvs_programmer.sv
`timescale 1ns/1ns
`default_nettype none
module hvs_programmer
  import hvs_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_WAIT_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  hvs_if.programmer       bus,
  input  wire logic       i_req,
  input  wire hvs_op_t    i_op,
  input  wire logic [7:0] i_sdi_byte,
  input  wire logic [7:0] i_sii_byte,
  output logic            o_ready,
  output logic            o_done,
  output logic [7:0]      o_rd_data
);
  typedef enum logic [3:0] {
    P_IDLE = 4'b0000,
    P_VCC  = 4'b0001,
    P_HV   = 4'b0010,
    P_REL  = 4'b0011,
    P_LOW  = 4'b0100,
    P_HIGH = 4'b0101,
    P_WAIT = 4'b0110,
    P_OFF  = 4'b0111,
    P_DOWN = 4'b1000
  } hvs_pst_t;

  typedef struct packed {
    hvs_pst_t    st;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [10:0] sdi_fr;
    logic [10:0] sii_fr;
    logic [7:0]  rd;
    logic        done;
    logic        vcc;
    logic        hv;
    logic        rel2;
    logic        serial_clock_input;
    logic        s1;
    logic        s2;
  } hvs_prg_t;

  hvs_prg_t q;
  hvs_prg_t d;

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    d.s1   = bus.serial_data_output;
    d.s2   = q.s1;
    d.cnt  = q.cnt + 16'h0001;
    case (q.st)
      P_IDLE:
      begin
        d.cnt = '0;
        if (i_req)
          case (i_op)
            HVS_ENTER:
            begin
              d.vcc  = 1'b1;
              d.hv   = 1'b0;
              d.rel2 = 1'b0;
              d.st   = P_VCC;
            end
            HVS_FRAME:
            begin
              // Caller orders erase, page fills and the closing no-op
              d.sdi_fr = hvs_frame(i_sdi_byte);
              d.sii_fr = hvs_frame(i_sii_byte);
              d.bitn   = '0;
              d.st     = P_LOW;
            end
            HVS_WAIT: d.st = P_WAIT;
            default:
            begin
              d.serial_clock_input = 1'b0;
              d.st  = P_OFF;
            end
          endcase
      end
      P_VCC:
        if (q.cnt == 16'(VCC_RAMP_CYC - 1))
        begin
          d.hv  = 1'b1;
          d.cnt = '0;
          d.st  = P_HV;
        end
      P_HV:
        // Hold covers both the 10 us select hold and the latch time
        if (q.cnt == 16'(SEL_HOLD_CYC - 1))
        begin
          d.rel2 = 1'b1;
          d.cnt  = '0;
          d.st   = P_REL;
        end
      P_REL:
        if (q.cnt == 16'(SETTLE_CYC - 1))
        begin
          d.done = 1'b1;
          d.st   = P_IDLE;
        end
      P_LOW:
        if (q.cnt == 16'(SCI_HALF_CYC - 1))
        begin
          d.serial_clock_input = 1'b1;
          d.cnt = '0;
          if (q.bitn < 4'h8)
            d.rd = {q.rd[6:0], q.s2};
          d.st = P_HIGH;
        end
      P_HIGH:
        if (q.cnt == 16'(SCI_HALF_CYC - 1))
        begin
          d.serial_clock_input    = 1'b0;
          d.cnt    = '0;
          d.sdi_fr = {q.sdi_fr[9:0], 1'b0};
          d.sii_fr = {q.sii_fr[9:0], 1'b0};
          if (q.bitn == 4'(FRAME_BITS - 1))
          begin
            d.done = 1'b1;
            d.st   = P_IDLE;
          end
          else
          begin
            d.bitn = q.bitn + 4'h1;
            d.st   = P_LOW;
          end
        end
      P_WAIT:
        // Guard skips the stale high level before busy shows
        if (q.cnt < 16'(WAIT_GUARD_CYC))
          d.cnt = q.cnt + 16'h0001;
        else if (q.s2)
        begin
          d.done = 1'b1;
          d.st   = P_IDLE;
        end
      P_OFF:
        if (q.cnt == 16'(SCI_HALF_CYC - 1))
        begin
          d.hv  = 1'b0;
          d.cnt = '0;
          d.st  = P_DOWN;
        end
      P_DOWN:
        if (q.cnt == 16'(SCI_HALF_CYC - 1))
        begin
          d.vcc  = 1'b0;
          d.rel2 = 1'b0;
          d.done = 1'b1;
          d.st   = P_IDLE;
        end
      default: d.st = P_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      q <= '0;
    else
      q <= d;
  end

  assign bus.vcc_on   = q.vcc;
  assign bus.hv_reset = q.hv;
  assign bus.sel_out  = SEL_PROG;
  assign bus.sel_oe_n = {q.rel2, 2'b00};
  assign bus.serial_data_input      = q.sdi_fr[10];
  assign bus.serial_instruction_input      = q.sii_fr[10];
  assign bus.serial_clock_input      = q.serial_clock_input;
  assign o_ready      = (q.st == P_IDLE);
  assign o_done       = q.done;
  assign o_rd_data    = q.rd;
endmodule // hvs_programmer
`default_nettype wire

// ### tb/hvs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module hvs_asserts
  import hvs_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_WAIT_CYC
) (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       vcc_on,
  input wire logic       hv_reset,
  input wire logic [2:0] sel_oe_n,
  input wire logic [2:0] sel,
  input wire logic       serial_data_input,
  input wire logic       serial_instruction_input,
  input wire logic       serial_clock_input,
  input wire logic       sdo_oe_n
);
  logic [15:0] hv_cnt_q;
  logic [15:0] rel_cnt_q;
  logic [3:0]  rise_cnt_q;
  logic        sci_q;

  // Hold and release counts saturate so a long session never wraps into a false pass; the rise count wraps per frame
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hv_cnt_q   <= 16'h0000;
      rel_cnt_q  <= 16'h0000;
      rise_cnt_q <= 4'h0;
      sci_q      <= 1'b0;
    end
    else
    begin
      hv_cnt_q  <= !hv_reset ? 16'h0000 : hv_cnt_q + {15'h0000, ~&hv_cnt_q};
      rel_cnt_q <= !sel_oe_n[2] ? 16'h0000 :
                   rel_cnt_q + {15'h0000, ~&rel_cnt_q};
      sci_q     <= serial_clock_input;
      if (!hv_reset)
        rise_cnt_q <= 4'h0;
      else if (serial_clock_input && !sci_q)
        rise_cnt_q <= (rise_cnt_q == 4'hA) ? 4'h0 : rise_cnt_q + 4'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_off_ready;
    !serial_clock_input && !hv_reset;
  endsequence
  sequence s_pad_bit;
    (serial_clock_input && !sci_q) && (rise_cnt_q == 4'h0 || rise_cnt_q >= 4'h9);
  endsequence

  a_sel_hold: assert property ($rose(sel_oe_n[2]) |-> hv_cnt_q >= SEL_HOLD_CYC)
    else $error("select released too early after high voltage");
  a_sel_value: assert property ($rose(hv_reset) |-> sel == SEL_PROG && vcc_on)
    else $error("select pins not 000 when high voltage applied");
  a_settle_wait: assert property ($rose(serial_clock_input) |-> rel_cnt_q >= SETTLE_CYC)
    else $error("serial clock started before settle time");
  a_sci_high: assert property ($rose(serial_clock_input) |-> serial_clock_input [*6])
    else $error("serial clock high phase too short");
  a_sci_low: assert property ($fell(serial_clock_input) |-> !serial_clock_input [*6])
    else $error("serial clock low phase too short");
  a_data_stable: assert property ($rose(serial_clock_input) |-> $stable(serial_data_input) && $stable(serial_instruction_input))
    else $error("serial data moved at clock rise");
  a_frame_pad: assert property (s_pad_bit |-> !serial_data_input && !serial_instruction_input)
    else $error("frame padding bit not zero");
  a_power_off: assert property ($fell(vcc_on) |-> s_off_ready)
    else $error("supply removed before clock low and reset high");
  a_rst_clock_low: assert property ($fell(hv_reset) |-> !serial_clock_input)
    else $error("reset left high voltage with clock high");
  a_exit_release: assert property ($fell(hv_reset) |-> ##[1:8] sdo_oe_n)
    else $error("data output still driven after mode exit");
endmodule // hvs_asserts
`default_nettype wire

// ### tb/hv_serial_programming_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module hv_serial_programming_port_tb;
  import hvs_pkg::*;
  localparam int SETTLE = 50;
  logic       i_clk;
  logic       i_resetn;
  logic       fuse;
  logic       req;
  hvs_op_t    op_q;
  logic [7:0] sdi_b;
  logic [7:0] sii_b;
  logic       o_ready;
  logic       o_done;
  logic [7:0] o_rd_data;
  logic       o_prog_mode;
  logic       o_busy;
  logic [7:0] o_lock_bits;
  logic [31:0] r;
  int         err_count;
  int         n_compared;
  // Row: code, sdi byte, sii byte, expected read byte
  // Codes: 01 frame, 11 frame and check, 02 wait, 03 keep fuse, 04 lock
  logic [31:0] rows [$] = '{
    32'h0180_4C00, 32'h0100_6400, 32'h0100_6C00, 32'h0200_0000,
    32'h0100_4C00, 32'h0400_0000,
    32'h0110_4C00, 32'h0103_0C00, 32'h01A5_2C00, 32'h0100_6D00,
    32'h015A_3C00, 32'h0100_7D00, 32'h0100_1C00, 32'h0100_6400,
    32'h0100_6C00, 32'h0200_0000,
    32'h0103_0C00, 32'h0196_2C00, 32'h0100_6D00, 32'h0169_3C00,
    32'h0100_7D00, 32'h0101_1C00, 32'h0100_6400, 32'h0100_6C00,
    32'h0200_0000, 32'h0100_4C00,
    32'h0102_4C00, 32'h0103_0C00, 32'h0100_1C00, 32'h0100_6800,
    32'h1100_6CA5, 32'h0100_7800, 32'h1100_6C5A, 32'h0101_1C00,
    32'h0100_6800, 32'h1100_6C96, 32'h0104_0C00, 32'h0100_6800,
    32'h1100_6CFF,
    32'h0111_4C00, 32'h0102_0C00, 32'h0100_1C00, 32'h01C3_2C00,
    32'h0100_6D00, 32'h0100_6400, 32'h0100_6C00, 32'h0200_0000,
    32'h0100_4C00, 32'h0103_4C00, 32'h0100_6800, 32'h1100_6CC3,
    32'h0101_0C00, 32'h0100_6800, 32'h1100_6CFF,
    32'h0300_0000, 32'h0180_4C00, 32'h0100_6400, 32'h0100_6C00,
    32'h0102_0C00, 32'h0200_0000, 32'h0100_4C00, 32'h0400_0000,
    32'h0103_4C00, 32'h0100_6800, 32'h1100_6CFF, 32'h0102_0C00,
    32'h0100_6800, 32'h1100_6CC3, 32'h0102_4C00, 32'h0103_0C00,
    32'h0100_1C00, 32'h0100_6800, 32'h1100_6CFF
  };

  hvs_if u_hvs_if ();

  hvs_programmer #(.SETTLE_CYC(SETTLE)) u_hvs_programmer (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .bus        (u_hvs_if),
    .i_req      (req),
    .i_op       (op_q),
    .i_sdi_byte (sdi_b),
    .i_sii_byte (sii_b),
    .o_ready    (o_ready),
    .o_done     (o_done),
    .o_rd_data  (o_rd_data)
  );

  hvs_device u_hvs_device (
    .i_clk              (i_clk),
    .i_resetn           (i_resetn),
    .bus                (u_hvs_if),
    .i_eeprom_keep_fuse (fuse),
    .o_prog_mode        (o_prog_mode),
    .o_busy             (o_busy),
    .o_lock_bits        (o_lock_bits)
  );

  hvs_asserts #(.SETTLE_CYC(SETTLE)) u_hvs_asserts (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .vcc_on   (u_hvs_if.vcc_on),
    .hv_reset (u_hvs_if.hv_reset),
    .sel_oe_n (u_hvs_if.sel_oe_n),
    .sel      (u_hvs_if.sel),
    .serial_data_input      (u_hvs_if.serial_data_input),
    .serial_instruction_input      (u_hvs_if.serial_instruction_input),
    .serial_clock_input      (u_hvs_if.serial_clock_input),
    .sdo_oe_n (u_hvs_if.sdo_oe_n)
  );

  always #10 i_clk = ~i_clk;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_op(input hvs_op_t op, input logic [7:0] d,
                       input logic [7:0] s);
    int n;
    @(posedge i_clk);
    req   <= 1'b1;
    op_q  <= op;
    sdi_b <= d;
    sii_b <= s;
    @(posedge i_clk);
    req <= 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20000)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20000)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, n, 20000);
    end
  endtask

  task automatic give_verdict;
    $display("Counts: compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    fuse = 1'b0;
    req = 1'b0;
    op_q = HVS_ENTER;
    sdi_b = 8'h00;
    sii_b = 8'h00;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    chk8(o_lock_bits, LOCK_RESET);
    chk1(o_prog_mode, 1'b0);
    chk1(u_hvs_if.serial_data_output, 1'b1);
    chk1(o_ready, 1'b1);
    do_op(HVS_ENTER, 8'h00, 8'h00);
    chk1(o_prog_mode, 1'b1);
    $display("Test reset and entry done");
    foreach (rows[k])
    begin
      r = rows[k];
      case (r[31:24])
        8'h03: fuse <= 1'b1;
        8'h04: chk8(o_lock_bits, LOCK_ERASED);
        8'h02:
        begin
          chk1(o_busy, 1'b1);
          do_op(HVS_WAIT, 8'h00, 8'h00);
          chk1(u_hvs_if.serial_data_output, 1'b1);
          chk1(o_busy, 1'b0);
        end
        default:
        begin
          do_op(HVS_FRAME, r[23:16], r[15:8]);
          if (r[28])
            chk8(o_rd_data, r[7:0]);
        end
      endcase
    end
    $display("Test table rows done");
    do_op(HVS_EXIT, 8'h00, 8'h00);
    chk1(o_prog_mode, 1'b0);
    do_op(HVS_ENTER, 8'h00, 8'h00);
    do_op(HVS_FRAME, CMD_ERASE, II_LOAD_CMD);
    do_op(HVS_FRAME, 8'h00, II_STROBE);
    do_op(HVS_FRAME, 8'h00, II_END);
    chk1(o_busy, 1'b1);
    do_op(HVS_EXIT, 8'h00, 8'h00);
    chk1(o_prog_mode, 1'b0);
    chk1(o_busy, 1'b0);
    chk1(u_hvs_if.serial_data_output, 1'b1);
    $display("Test exit during erase done");
    give_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    give_verdict();
  end
endmodule // hv_serial_programming_port_tb
`default_nettype wire
